/* cmtu_defs.vh */
// constants for the coprocessor move transfer unit
// assumes every user includes it by bare name
`ifndef CMTU_DEFS_VH
`define CMTU_DEFS_VH

// ========
// register bus map (byte addresses)
`define CMTU_ADDR_W          8
`define CMTU_OFF_CTRL        8'h00
`define CMTU_OFF_STATUS      8'h04
`define CMTU_OFF_INDEX       8'h08
`define CMTU_OFF_DATA_LO     8'h0C
`define CMTU_OFF_DATA_HI     8'h10
`define CMTU_OFF_ADDR        8'h14

// ========
// control register fields and reset values
`define CMTU_CTRL_ORDER_BIT  0
`define CMTU_CTRL_ID_LSB     1
`define CMTU_CTRL_ID_MSB     3
`define CMTU_ORDER_RST       1'h0
`define CMTU_ID_RST          3'h0

// ========
// status register fields
`define CMTU_STAT_BUSY_BIT   0
`define CMTU_STAT_DBL_BIT    1
`define CMTU_STAT_IGN_BIT    2
`define CMTU_STAT_REM_LSB    8
`define CMTU_STAT_REM_MSB    13
`define CMTU_STAT_IDX_LSB    16
`define CMTU_STAT_IDX_MSB    20

// ========
// instruction word fields
`define CMTU_INS_ID_MSB      31
`define CMTU_INS_ID_LSB      29
`define CMTU_INS_REG_MSB     20
`define CMTU_INS_REG_LSB     16
`define CMTU_INS_OP_MSB      15
`define CMTU_INS_OP_LSB      9
`define CMTU_INS_TYPE_BIT    8
`define CMTU_INS_SIZE_BIT    7
`define CMTU_OP_TO_HOST      7'h27
`define CMTU_OP_FROM_MEM     7'h46

// ========
// transfer sizing
`define CMTU_NREGS           32
`define CMTU_IDX_W           5
`define CMTU_CNT_W           6
`define CMTU_CNT_ZERO_WORDS  6'h20
`define CMTU_WORD_STEP       32'h00000020
`define CMTU_WORD_ZERO       32'h00000000

`endif

/* cmtu_half_sel.v */
// half-word selector and merger for 64-bit coprocessor registers
// assumes the caller supplies the word-order bit and the transfer phase
`timescale 1ns/10ps
`include "cmtu_defs.vh"

module cmtu_half_sel (
    input  wire [63:0] reg_val_in,
    input  wire [31:0] word_in,
    input  wire        order_in,
    input  wire        phase_in,
    output wire [31:0] word_out,
    output wire [63:0] merged_out
);

    // ========
    // half choice
    // order 1 moves the low half first, order 0 the high half first
    wire pick_low;
    assign pick_low = order_in ^ phase_in;

    assign word_out   = pick_low ? reg_val_in[31:0] : reg_val_in[63:32];
    assign merged_out = pick_low ? {reg_val_in[63:32], word_in}
                                 : {word_in, reg_val_in[31:0]};

endmodule // cmtu_half_sel

/* cmtu_move_unit.v */
// coprocessor move transfer unit: register file, host moves, block loads
// assumes one clock, the host presents commands and acks words in sync
//
// Summary of operation
// RL1: single move sends one full 32-bit source register word to host.
// RL2: double move sends one 64-bit register as two successive halves.
// RL3: order bit one sends or receives the lower half first.
// RL4: order bit zero handles the upper half first.
// RL5: order bit resets to zero, upper half first.
// RL6: register count zero yields exactly 32 word transfers.
// RL7: register count 1..31 yields that many word transfers.
// RL8: host keeps register counts within 0 to 31.
// RL9: host gives even counts for double loads; odd is undefined.
// RL10: postincrement adds 32 to the address after each word.
// RL11: destination steps per word, or per second word for double.
// RL12: single constant count 32 encodes as 0, others unchanged.
// RL13: double constant count 16 encodes as 0, others as twice count.
// RL14: host keeps constant counts 1..32 single, 1..16 double.
// RL15: host assembler uses count one when omitted.
// RL16: predecrement subtracts 32 before each word transfer.
// RL17: host pointer starts just past the first value for predecrement.
// RL18: act only on instructions whose select field matches own id.
// RL19: type and size bits pick integer, single or double sequencing.
`timescale 1ns/10ps
`include "cmtu_defs.vh"

module cmtu_move_unit (
    input  wire                      clk_in,
    input  wire                      reset_n_in,
    // register bus
    input  wire [`CMTU_ADDR_W-1:0]   bus_addr_in,
    input  wire [31:0]               bus_wdata_in,
    input  wire                      bus_wr_in,
    input  wire                      bus_rd_in,
    output reg  [31:0]               bus_rdata_out,
    // instruction port
    input  wire                      cmd_valid_in,
    input  wire [31:0]               cmd_word_in,
    input  wire [4:0]                cmd_count_in,
    input  wire [31:0]               cmd_pointer_in,
    input  wire                      cmd_predec_in,
    output wire                      cmd_ready_out,
    // words to host general registers
    output wire                      hreg_valid_out,
    output reg  [31:0]               hreg_data_out,
    output reg                       hreg_sel_out,
    input  wire                      hreg_ready_in,
    // block load from host memory
    output wire                      mem_req_out,
    output reg  [31:0]               mem_addr_out,
    input  wire                      mem_ack_in,
    input  wire [31:0]               mem_data_in
);

    // ========
    // states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_HOST = 2'b01;
    localparam [1:0] ST_MEM  = 2'b10;

    // ========
    // functions
    // a zero count field stands for the full run of 32 words
    function [`CMTU_CNT_W-1:0] words_of;
        input [4:0] field;
        begin
            if (field == 5'h00) begin
                words_of = `CMTU_CNT_ZERO_WORDS;
            end else begin
                words_of = {1'b0, field};
            end
        end
    endfunction

    function [`CMTU_IDX_W-1:0] next_idx;
        input [`CMTU_IDX_W-1:0] idx;
        begin
            next_idx = idx + 5'h01;
        end
    endfunction

    // ========
    // storage
    reg  [63:0]              file_reg [0:`CMTU_NREGS-1];
    reg  [1:0]               state_reg;
    reg                      order_reg;
    reg  [2:0]               own_id_reg;
    reg  [`CMTU_IDX_W-1:0]   sw_idx_reg;
    reg  [`CMTU_IDX_W-1:0]   idx_reg;
    reg  [`CMTU_CNT_W-1:0]   remain_reg;
    reg                      double_reg;
    reg                      phase_reg;
    reg                      predec_reg;
    reg                      ignored_reg;
    integer                  i;

    // ========
    // instruction decode
    wire [2:0]             ins_id;
    wire [6:0]             ins_op;
    wire [`CMTU_IDX_W-1:0] ins_reg;
    wire                   ins_dbl;
    wire                   id_match;
    wire                   op_host;
    wire                   op_mem;
    wire                   cmd_take;

    assign ins_id   = cmd_word_in[`CMTU_INS_ID_MSB:`CMTU_INS_ID_LSB];
    assign ins_op   = cmd_word_in[`CMTU_INS_OP_MSB:`CMTU_INS_OP_LSB];
    assign ins_reg  = cmd_word_in[`CMTU_INS_REG_MSB:`CMTU_INS_REG_LSB];
    // RL19: double only for float type with size set
    assign ins_dbl  = cmd_word_in[`CMTU_INS_TYPE_BIT] & cmd_word_in[`CMTU_INS_SIZE_BIT];
    // RL18: id compare gates every command
    assign id_match = (ins_id == own_id_reg);
    assign op_host  = id_match & (ins_op == `CMTU_OP_TO_HOST);
    assign op_mem   = id_match & (ins_op == `CMTU_OP_FROM_MEM);

    assign cmd_ready_out = (state_reg == ST_IDLE);
    assign cmd_take      = cmd_valid_in & cmd_ready_out;

    // ========
    // handshakes
    wire host_step;
    wire mem_step;
    wire last_word;

    assign hreg_valid_out = (state_reg == ST_HOST);
    assign mem_req_out    = (state_reg == ST_MEM);
    assign host_step      = hreg_valid_out & hreg_ready_in;
    assign mem_step       = mem_req_out & mem_ack_in;
    assign last_word      = (remain_reg == 6'h01);

    // ========
    // half selection for outgoing and incoming double words
    reg  [`CMTU_IDX_W-1:0] sel_idx;
    reg                    sel_phase;
    wire [31:0]            half_word;
    wire [63:0]            half_merged;

    always @* begin
        sel_idx   = idx_reg;
        sel_phase = phase_reg;
        if (cmd_take) begin
            sel_idx   = ins_reg;
            sel_phase = 1'b0;
        end else if (host_step) begin
            sel_phase = 1'b1;
        end
    end

    // RL3: order bit picks which half goes first
    // RL4: order zero means high half first
    cmtu_half_sel u_half (
        .reg_val_in (file_reg[sel_idx]),
        .word_in    (mem_data_in),
        .order_in   (order_reg),
        .phase_in   (sel_phase),
        .word_out   (half_word),
        .merged_out (half_merged)
    );

    // ========
    // sequencer
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg     <= ST_IDLE;
            idx_reg       <= 5'h00;
            remain_reg    <= 6'h00;
            double_reg    <= 1'b0;
            phase_reg     <= 1'b0;
            predec_reg    <= 1'b0;
            ignored_reg   <= 1'b0;
            hreg_data_out <= 32'h00000000;
            hreg_sel_out  <= 1'b0;
            mem_addr_out  <= 32'h00000000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_take) begin
                        idx_reg    <= ins_reg;
                        double_reg <= ins_dbl;
                        phase_reg  <= 1'b0;
                        predec_reg <= cmd_predec_in;
                        ignored_reg <= ~(op_host | op_mem);
                        if (op_host) begin
                            state_reg    <= ST_HOST;
                            hreg_sel_out <= 1'b0;
                            // RL1: single moves send the low 32 bits whole
                            if (ins_dbl) begin
                                hreg_data_out <= half_word;
                            end else begin
                                hreg_data_out <= file_reg[ins_reg][31:0];
                            end
                        end else if (op_mem) begin
                            state_reg  <= ST_MEM;
                            // RL6: zero field gives 32 words
                            // RL7: 1..31 gives that many words
                            // RL12: constant single count decodes the same
                            // RL13: double field already counts words
                            remain_reg <= words_of(cmd_count_in);
                            // RL16: first fetch sits 32 below the pointer
                            // RL17: pointer is taken as one past the value
                            if (cmd_predec_in) begin
                                mem_addr_out <= cmd_pointer_in - `CMTU_WORD_STEP;
                            end else begin
                                mem_addr_out <= cmd_pointer_in;
                            end
                        end
                    end
                end
                ST_HOST: begin
                    if (host_step) begin
                        // RL2: second half follows for doubles
                        if (double_reg && !phase_reg) begin
                            phase_reg     <= 1'b1;
                            hreg_sel_out  <= 1'b1;
                            hreg_data_out <= half_word;
                        end else begin
                            state_reg    <= ST_IDLE;
                            phase_reg    <= 1'b0;
                            hreg_sel_out <= 1'b0;
                        end
                    end
                end
                ST_MEM: begin
                    if (mem_step) begin
                        remain_reg <= remain_reg - 6'h01;
                        // RL10: postincrement after each word
                        // RL16: predecrement ahead of the next word
                        if (predec_reg) begin
                            mem_addr_out <= mem_addr_out - `CMTU_WORD_STEP;
                        end else begin
                            mem_addr_out <= mem_addr_out + `CMTU_WORD_STEP;
                        end
                        // RL11: step per word, or every second word
                        if (double_reg) begin
                            phase_reg <= ~phase_reg;
                            if (phase_reg) begin
                                idx_reg <= next_idx(idx_reg);
                            end
                        end else begin
                            idx_reg <= next_idx(idx_reg);
                        end
                        // RL9: odd double counts end mid-register
                        if (last_word) begin
                            state_reg <= ST_IDLE;
                            phase_reg <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ========
    // register file writes
    // engine owns the file while busy; software data writes are
    // dropped then, so a load is never torn by a bus write
    wire sw_file_ok;
    wire sw_wr_lo;
    wire sw_wr_hi;

    assign sw_file_ok = bus_wr_in & (state_reg == ST_IDLE);
    assign sw_wr_lo   = sw_file_ok & (bus_addr_in == `CMTU_OFF_DATA_LO);
    assign sw_wr_hi   = sw_file_ok & (bus_addr_in == `CMTU_OFF_DATA_HI);

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (i = 0; i < `CMTU_NREGS; i = i + 1) begin
                file_reg[i[`CMTU_IDX_W-1:0]] <= 64'h0000000000000000;
            end
        end else begin
            if (mem_step) begin
                // RL19: integer and single fill the low word and zero the high word
                if (double_reg) begin
                    file_reg[idx_reg] <= half_merged;
                end else begin
                    file_reg[idx_reg] <= {`CMTU_WORD_ZERO, mem_data_in};
                end
            end else if (sw_wr_lo) begin
                file_reg[sw_idx_reg][31:0] <= bus_wdata_in;
            end else if (sw_wr_hi) begin
                file_reg[sw_idx_reg][63:32] <= bus_wdata_in;
            end
        end
    end

    // ========
    // control registers
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // RL5: upper half first after reset
            order_reg  <= `CMTU_ORDER_RST;
            own_id_reg <= `CMTU_ID_RST;
            sw_idx_reg <= 5'h00;
        end else if (bus_wr_in) begin
            if (bus_addr_in == `CMTU_OFF_CTRL) begin
                order_reg  <= bus_wdata_in[`CMTU_CTRL_ORDER_BIT];
                own_id_reg <= bus_wdata_in[`CMTU_CTRL_ID_MSB:`CMTU_CTRL_ID_LSB];
            end else if (bus_addr_in == `CMTU_OFF_INDEX) begin
                sw_idx_reg <= bus_wdata_in[`CMTU_IDX_W-1:0];
            end
        end
    end

    // ========
    // read path, data valid the cycle after the strobe
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        if (bus_addr_in == `CMTU_OFF_CTRL) begin
            rd_mux[`CMTU_CTRL_ORDER_BIT] = order_reg;
            rd_mux[`CMTU_CTRL_ID_MSB:`CMTU_CTRL_ID_LSB] = own_id_reg;
        end else if (bus_addr_in == `CMTU_OFF_STATUS) begin
            rd_mux[`CMTU_STAT_BUSY_BIT] = (state_reg != ST_IDLE);
            rd_mux[`CMTU_STAT_DBL_BIT]  = double_reg;
            rd_mux[`CMTU_STAT_IGN_BIT]  = ignored_reg;
            rd_mux[`CMTU_STAT_REM_MSB:`CMTU_STAT_REM_LSB] = remain_reg;
            rd_mux[`CMTU_STAT_IDX_MSB:`CMTU_STAT_IDX_LSB] = idx_reg;
        end else if (bus_addr_in == `CMTU_OFF_INDEX) begin
            rd_mux[`CMTU_IDX_W-1:0] = sw_idx_reg;
        end else if (bus_addr_in == `CMTU_OFF_DATA_LO) begin
            rd_mux = file_reg[sw_idx_reg][31:0];
        end else if (bus_addr_in == `CMTU_OFF_DATA_HI) begin
            rd_mux = file_reg[sw_idx_reg][63:32];
        end else if (bus_addr_in == `CMTU_OFF_ADDR) begin
            rd_mux = mem_addr_out;
        end
    end

    // unmapped addresses read as zero; data only in the cycle after
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_rdata_out <= 32'h00000000;
        end else if (bus_rd_in) begin
            bus_rdata_out <= rd_mux;
        end else begin
            bus_rdata_out <= 32'h00000000;
        end
    end

endmodule // cmtu_move_unit

/* cmtu_host_model.sv */
// host side model: memory responder and host register sink
// assumes one clock shared with the move unit, seed set by the bench
`timescale 1ns/10ps

module cmtu_host_model #(
    parameter logic [31:0] KEY = 32'h3C5A96E1
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        mem_req_in,
    input  wire logic [31:0] mem_addr_in,
    output logic             mem_ack_out = 1'b0,
    output logic      [31:0] mem_data_out = 32'h00000000,
    input  wire logic        hreg_valid_in,
    output logic             hreg_ready_out = 1'b0
);
    // ========
    // responses just after each edge, random stalls
    always begin
        @(posedge clk_in);
        #1;
        mem_ack_out = reset_n_in && mem_req_in && ($urandom % 4 != 0);
        // released bus inverts its last value each cycle, so every second idle cycle repeats a stale word
        mem_data_out = mem_ack_out ? (~mem_addr_in ^ KEY) : ~mem_data_out;
        hreg_ready_out = reset_n_in && hreg_valid_in && ($urandom % 3 != 0);
    end
endmodule // cmtu_host_model

/* cmtu_move_unit_assertions.sv */
// checker for the move unit, sees only its top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
`include "cmtu_defs.vh"

module cmtu_move_chk (
    input wire logic                    clk_in,
    input wire logic                    reset_n_in,
    input wire logic [`CMTU_ADDR_W-1:0] bus_addr_in,
    input wire logic [31:0]             bus_wdata_in,
    input wire logic                    bus_wr_in,
    input wire logic                    bus_rd_in,
    input wire logic [31:0]             bus_rdata_out,
    input wire logic                    cmd_valid_in,
    input wire logic [31:0]             cmd_word_in,
    input wire logic [4:0]              cmd_count_in,
    input wire logic [31:0]             cmd_pointer_in,
    input wire logic                    cmd_predec_in,
    input wire logic                    cmd_ready_out,
    input wire logic                    hreg_valid_out,
    input wire logic [31:0]             hreg_data_out,
    input wire logic                    hreg_sel_out,
    input wire logic                    hreg_ready_in,
    input wire logic                    mem_req_out,
    input wire logic [31:0]             mem_addr_out,
    input wire logic                    mem_ack_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ========
    // shadow of id, mode and word count
    logic [2:0] own_reg;
    logic       pd_reg;
    logic       dbl_reg;
    logic [5:0] exp_reg;
    logic [5:0] got_reg;
    wire        take = cmd_valid_in && cmd_ready_out;
    wire        mine = cmd_word_in[31:29] == own_reg;
    wire        load = take && mine && cmd_word_in[15:9] == `CMTU_OP_FROM_MEM;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            own_reg <= 3'h0;
            pd_reg  <= 1'b0;
            dbl_reg <= 1'b0;
            exp_reg <= 6'h00;
            got_reg <= 6'h00;
        end else begin
            if (bus_wr_in && bus_addr_in == `CMTU_OFF_CTRL)
                own_reg <= bus_wdata_in[3:1];
            if (take) begin
                pd_reg  <= cmd_predec_in;
                dbl_reg <= cmd_word_in[8] & cmd_word_in[7];
            end
            if (load) begin
                exp_reg <= (cmd_count_in == 5'h00) ? 6'h20 : {1'b0, cmd_count_in};
                got_reg <= 6'h00;
            end else if (mem_req_out && mem_ack_in) begin
                got_reg <= got_reg + 6'h01;
            end
        end
    end
    // ========
    AST_RD_IDLE: assert property (
        !bus_rd_in |=> bus_rdata_out == 32'h0) else $error("read data outside slot");
    AST_MEM_HOLD: assert property (
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("request not held");
    AST_POSTINC: assert property (
        mem_req_out && mem_ack_in && !pd_reg |=>
        !mem_req_out || mem_addr_out == $past(mem_addr_out) + 32'h20)
        else $error("address not advanced by 32");
    AST_PREDEC: assert property (
        mem_req_out && mem_ack_in && pd_reg |=>
        !mem_req_out || mem_addr_out == $past(mem_addr_out) - 32'h20)
        else $error("address not reduced by 32");
    AST_FIRST: assert property (
        load |=> mem_req_out && mem_addr_out == ($past(cmd_predec_in) ?
        $past(cmd_pointer_in) - 32'h20 : $past(cmd_pointer_in)))
        else $error("first load address wrong");
    AST_IGNORE: assert property (
        take && !mine |=> cmd_ready_out && !mem_req_out && !hreg_valid_out)
        else $error("foreign command acted on");
    AST_COUNT: assert property (
        $fell(mem_req_out) |-> got_reg == exp_reg) else $error("word count wrong");
    AST_HREG_HOLD: assert property (
        hreg_valid_out && !hreg_ready_in |=>
        hreg_valid_out && $stable(hreg_data_out) && $stable(hreg_sel_out))
        else $error("host word not held");
    AST_DBL_SECOND: assert property (
        hreg_valid_out && hreg_ready_in && !hreg_sel_out && dbl_reg |=>
        hreg_valid_out && hreg_sel_out) else $error("second half missing");
    AST_SINGLE_ONE: assert property (
        hreg_valid_out && hreg_ready_in && !dbl_reg |=> !hreg_valid_out && cmd_ready_out)
        else $error("single move not one word");
    AST_BUSY: assert property (
        hreg_valid_out || mem_req_out |-> !cmd_ready_out) else $error("ready while busy");
endmodule // cmtu_move_chk

bind cmtu_move_unit cmtu_move_chk cmtu_move_chk_inst (.clk_in, .reset_n_in, .bus_addr_in,
    .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out, .cmd_valid_in, .cmd_word_in,
    .cmd_count_in, .cmd_pointer_in, .cmd_predec_in, .cmd_ready_out, .hreg_valid_out,
    .hreg_data_out, .hreg_sel_out, .hreg_ready_in, .mem_req_out, .mem_addr_out, .mem_ack_in);

/* tb_top.sv */
// self-checking bench for the move unit with a host model
// assumes the host model answers with ~addr ^ KEY on each memory word
`timescale 1ns/10ps
`include "cmtu_defs.vh"

module tb_top;
    localparam logic [31:0] KEY = 32'h3C5A96E1;
    logic clk_in = 0, reset_n_in = 0, bus_wr_in = 0, bus_rd_in = 0, cmd_valid_in = 0;
    logic cmd_predec_in = 0, cmd_ready_out, hreg_valid_out, hreg_sel_out, hreg_ready_in;
    logic mem_req_out, mem_ack_in, order = 0, rd_p = 0;
    logic [7:0]  bus_addr_in = 8'h00;
    logic [4:0]  cmd_count_in = 5'h00;
    logic [2:0]  own = 3'h0;
    logic [31:0] bus_wdata_in = 0, cmd_word_in = 0, cmd_pointer_in = 0, bus_rdata_out;
    logic [31:0] hreg_data_out, mem_addr_out, mem_data_in;
    logic [63:0] rf[32], e, rq[$];
    logic [32:0] hq[$];
    logic [31:0] aq[$];
    int fails = 0, total_checks = 0;
    int lt[6][5] = '{'{0,32,0,0,0}, '{0,31,1,0,31}, '{0,1,0,1,7},
                     '{1,16,0,0,2}, '{1,3,1,1,30}, '{1,1,0,1,5}};

    always #4 clk_in = ~clk_in;

    cmtu_move_unit cmtu_move_unit_inst (.clk_in, .reset_n_in, .bus_addr_in, .bus_wdata_in,
        .bus_wr_in, .bus_rd_in, .bus_rdata_out, .cmd_valid_in, .cmd_word_in, .cmd_count_in,
        .cmd_pointer_in, .cmd_predec_in, .cmd_ready_out, .hreg_valid_out, .hreg_data_out,
        .hreg_sel_out, .hreg_ready_in, .mem_req_out, .mem_addr_out, .mem_ack_in,
        .mem_data_in);
    cmtu_host_model #(.KEY(KEY)) cmtu_host_model_inst (.clk_in,
        .reset_n_in, .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
        .mem_ack_out(mem_ack_in), .mem_data_out(mem_data_in),
        .hreg_valid_in(hreg_valid_out), .hreg_ready_out(hreg_ready_in));

    // ========
    // compare and bus tasks
    task chk(string n, logic [63:0] x, logic [63:0] g);
        total_checks++;
        if (x !== g) begin
            fails++;
            $display("MISMATCH %0s expected %h seen %h", n, x, g);
        end
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        bus_wr_in <= 1; bus_addr_in <= a; bus_wdata_in <= d;
        @(posedge clk_in);
        bus_wr_in <= 0;
    endtask
    task rd(logic [7:0] a, logic [31:0] m, logic [31:0] x);
        rq.push_back({m, x & m});
        @(posedge clk_in);
        bus_rd_in <= 1; bus_addr_in <= a;
        @(posedge clk_in);
        bus_rd_in <= 0;
    endtask
    task issue(logic [2:0] id, logic [4:0] r, logic [6:0] op, logic t, logic s,
               logic [4:0] cnt, logic [31:0] p, logic pd);
        @(posedge clk_in);
        cmd_valid_in <= 1; cmd_word_in <= {id, 8'h00, r, op, t, s, 7'h00};
        cmd_count_in <= cnt; cmd_pointer_in <= p; cmd_predec_in <= pd;
        @(posedge clk_in);
        cmd_valid_in <= 0;
        repeat (300) begin
            @(posedge clk_in);
            if (cmd_ready_out === 1'b1) break;
        end
        chk("ready", 1, cmd_ready_out);
    endtask
    task move(logic t, logic s, logic [4:0] r);
        if (t & s) begin
            hq.push_back({1'b0, order ? rf[r][31:0] : rf[r][63:32]});
            hq.push_back({1'b1, order ? rf[r][63:32] : rf[r][31:0]});
        end else hq.push_back({1'b0, rf[r][31:0]});
        issue(own, r, `CMTU_OP_TO_HOST, t, s, 5'($urandom), $urandom, 0);
    endtask
    task load(logic dbl, int cnt, logic [4:0] r, logic pd);
        logic [4:0] fld, idx;
        logic [31:0] p, a, d;
        fld = dbl ? ((cnt == 16) ? 0 : 2 * cnt) : ((cnt == 32) ? 0 : cnt);
        p = $urandom;
        a = pd ? p - 32'h20 : p;
        idx = r;
        for (int w = 0; w < ((fld == 0) ? 32 : fld); w++) begin
            aq.push_back(a);
            d = ~a ^ KEY;
            if (!dbl) rf[idx] = {32'h0, d};
            else if ((w % 2 == 0) != order) rf[idx][63:32] = d;
            else rf[idx][31:0] = d;
            if (!dbl || w % 2 == 1) idx++;
            a = pd ? a - 32'h20 : a + 32'h20;
        end
        issue(own, r, `CMTU_OP_FROM_MEM, dbl, dbl, fld, p, pd);
        for (int i = 0; i < 32; i++) begin
            wr(`CMTU_OFF_INDEX, i);
            rd(`CMTU_OFF_DATA_LO, 32'hFFFFFFFF, rf[i][31:0]);
            rd(`CMTU_OFF_DATA_HI, 32'hFFFFFFFF, rf[i][63:32]);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ========
    // result watcher takes the oldest note per result
    always @(posedge clk_in) begin
        if (rd_p) begin
            e = rq.pop_front();
            chk("rdata", e[31:0], bus_rdata_out & e[63:32]);
        end
        rd_p <= bus_rd_in;
        if (hreg_valid_out === 1'b1 && hreg_ready_in === 1'b1)
            chk("hreg", hq.pop_front(), {hreg_sel_out, hreg_data_out});
        if (mem_req_out === 1'b1 && mem_ack_in === 1'b1)
            chk("maddr", aq.pop_front(), mem_addr_out);
    end

    initial begin
        #480000;
        fails++;
        end_sim;
    end

    initial begin
        void'($urandom(84));
        for (int i = 0; i < 32; i++) rf[i] = 64'h0;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1;
        rd(`CMTU_OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        for (int o = 0; o < 2; o++) begin
            wr(`CMTU_OFF_CTRL, o);
            order = o;
            wr(`CMTU_OFF_INDEX, 3);
            rf[3] = {$urandom, $urandom};
            wr(`CMTU_OFF_DATA_LO, rf[3][31:0]);
            wr(`CMTU_OFF_DATA_HI, rf[3][63:32]);
            move(0, 0, 3);
            move(1, 1, 3);
            move(1, 0, 3);
        end
        $display("test host moves done");
        wr(`CMTU_OFF_CTRL, 32'h0000000A);
        order = 0;
        issue(3'h0, 3, `CMTU_OP_TO_HOST, 1, 1, 0, 0, 0);
        rd(`CMTU_OFF_STATUS, 32'h4, 32'h4);
        own = 3'h5;
        issue(own, 3, 7'h11, 0, 0, 0, 0, 0);
        rd(`CMTU_OFF_STATUS, 32'h4, 32'h4);
        move(1, 1, 3);
        $display("test select done");
        foreach (lt[k]) begin
            order = lt[k][3];
            wr(`CMTU_OFF_CTRL, {own, order});
            load(lt[k][0], lt[k][1], lt[k][4], lt[k][2]);
        end
        $display("test block loads done");
        repeat (3) @(posedge clk_in);
        chk("pending", 0, hq.size() + aq.size() + rq.size());
        end_sim;
    end
endmodule // tb_top
